// ---- rtl/sbcr_consts.svh ----
/*
  constants of the serial-bus configuration ROM info register group:
  register offsets, field positions, reset values and ROM addresses.
  assumes it is included by bare name wherever these values are needed.
*/
`ifndef SBCR_CONSTS_SVH
`define SBCR_CONSTS_SVH

`define SBCR_OFF_HDR        8'h18
`define SBCR_OFF_BUSID      8'h1C
`define SBCR_OFF_OPTS       8'h20

`define SBCR_BUSID_VAL      32'h31333934

`define SBCR_ROM_HDR_ADDR   48'hFFFFF0000400
`define SBCR_ROM_BUSID_ADDR 48'hFFFFF0000404
`define SBCR_ROM_OPTS_ADDR  48'hFFFFF0000408

`define SBCR_HDR_RST        32'h00000000
`define SBCR_HDR_WMASK      32'hFFFFFFFF
`define SBCR_CRC_MSB        15
`define SBCR_CRC_LSB        0

`define SBCR_OPTS_RST       32'h00000000
`define SBCR_OPTS_WMASK     32'hF8FF00F0
`define SBCR_OPTS_RO_VAL    32'h00000002
`define SBCR_MAXREC_MSB     15
`define SBCR_MAXREC_LSB     12
`define SBCR_MAXREC_RST     4'hA

`define SBCR_RD_UNMAPPED    32'h00000000

`endif

// ---- rtl/sbcr_pkg.sv ----
/*
  types and shared helpers of the configuration ROM info register group.
  assumes sbcr_consts.svh is on the include path.
*/
`include "sbcr_consts.svh"

package sbcr_pkg;

  typedef enum logic [1:0] {
    SBCR_Q_NONE,
    SBCR_Q_HDR,
    SBCR_Q_BUSID,
    SBCR_Q_OPTS
  } sbcr_quad_t;

  // byte-lane merge of a write, limited to the writable bits
  function automatic logic [31:0] sbcr_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel,
                                             input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // quadlet decode of a remote configuration ROM address
  function automatic sbcr_quad_t sbcr_rom_decode(input logic [47:0] addr);
    sbcr_quad_t q;
    q = SBCR_Q_NONE;
    if (addr == `SBCR_ROM_HDR_ADDR) begin
      q = SBCR_Q_HDR;
    end else if (addr == `SBCR_ROM_BUSID_ADDR) begin
      q = SBCR_Q_BUSID;
    end else if (addr == `SBCR_ROM_OPTS_ADDR) begin
      q = SBCR_Q_OPTS;
    end
    return q;
  endfunction

endpackage

// ---- rtl/sbcr_rom_port.sv ----
/*
  remote read port: answers a configuration ROM quadlet read one cycle later.
  assumes the requester is on clk_i and that the quadlet inputs are live values.
*/
`timescale 1ns/1ns
`default_nettype none

module sbcr_rom_port
  import sbcr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [47:0] addr_i,
  input  wire logic [31:0] hdr_i,
  input  wire logic [31:0] busid_i,
  input  wire logic [31:0] opts_i,
  output logic             ack_o,
  output logic [31:0]      data_o,
  output logic             hit_o
);

  logic        ack_q, ack_d;
  logic        hit_q, hit_d;
  logic [31:0] data_q, data_d;
  sbcr_quad_t  quad;

  always_comb begin
    quad   = sbcr_rom_decode(addr_i);
    ack_d  = req_i;
    hit_d  = 1'b0;
    data_d = data_q;
    if (req_i) begin
      hit_d  = (quad != SBCR_Q_NONE);
      data_d = `SBCR_RD_UNMAPPED;
      unique case (quad)
        SBCR_Q_HDR:   data_d = hdr_i;
        SBCR_Q_BUSID: data_d = busid_i;
        SBCR_Q_OPTS:  data_d = opts_i;
        SBCR_Q_NONE:  data_d = `SBCR_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      hit_q  <= 1'b0;
      data_q <= 32'h00000000;
    end else begin
      ack_q  <= ack_d;
      hit_q  <= hit_d;
      data_q <= data_d;
    end
  end

  assign ack_o  = ack_q;
  assign hit_o  = hit_q;
  assign data_o = data_q;

endmodule

`default_nettype wire

// ---- rtl/sbcr_regs.sv ----
/*
  configuration ROM header, bus identification and bus options registers,
  reached over a classic wishbone slave and read by remote nodes via the rom port.
  assumes eeprom, soft reset and remote requests all come from logic on clk_i.
  assumes one wishbone access at a time, with cyc and stb low between accesses.
  assumes the eeprom loader pulses its load strobe for one cycle per checksum.
  no link activate input: keeping the length fields valid is left to software.
*/
// Local design decision: register access over Wishbone.
// Contract
// - header register is the first configuration ROM quadlet at its fixed address.
// - with eeprom attached, the 16-bit checksum field is loaded from it.
// - without eeprom, upper header bits reset to zero; checksum value undefined.
// - bus identification returns the fixed ascii bus name; writes ignored.
// - bus options register is the second info quadlet, host offset 20h.
// - max request field codes 2^(n+1) bytes; hard reset 2048; soft reset keeps.
`timescale 1ns/1ns
`default_nettype none

module sbcr_regs
  import sbcr_pkg::*;
#(
  parameter int ADR_W = 8
)(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             soft_rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             eeprom_present_i,
  input  wire logic             eeprom_crc_load_i,
  input  wire logic [15:0]      eeprom_crc_i,
  input  wire logic             rom_rd_req_i,
  input  wire logic [47:0]      rom_rd_addr_i,
  output logic                  rom_rd_ack_o,
  output logic [31:0]           rom_rd_data_o,
  output logic                  rom_rd_hit_o
);

  logic [31:0] hdr_q;
  logic [31:0] hdr_d;
  logic [31:0] opts_q;
  logic [31:0] opts_d;
  logic [3:0]  maxrec_q;
  logic [3:0]  maxrec_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;

  logic             req;
  logic             take;
  logic             wr_en;
  logic             hdr_we;
  logic             opts_we;
  logic [ADR_W-1:0] word_adr;
  sbcr_quad_t       host_sel;
  logic [31:0]      opts_view;
  logic [31:0]      busid_view;

  // host register decode; the read mux and both write strobes share it
  function automatic sbcr_quad_t host_decode(input logic [ADR_W-1:0] a);
    sbcr_quad_t q;
    q = SBCR_Q_NONE;
    if (a == ADR_W'(`SBCR_OFF_HDR)) begin
      q = SBCR_Q_HDR;
    end else if (a == ADR_W'(`SBCR_OFF_BUSID)) begin
      q = SBCR_Q_BUSID;
    end else if (a == ADR_W'(`SBCR_OFF_OPTS)) begin
      q = SBCR_Q_OPTS;
    end
    return q;
  endfunction

  // low two address bits ignored; unmapped words read zero and drop writes
  assign word_adr = {wb_adr_i[ADR_W-1:2], 2'b00};
  assign host_sel = host_decode(word_adr);
  assign req      = wb_cyc_i & wb_stb_i;

  // a request is taken in its first cycle and answered in the next
  assign take     = req & ~ack_q;

  // write lands on the edge the master samples ack, never earlier
  assign wr_en    = req & wb_we_i & ack_q;

  // a soft reset in the same cycle wins, so such a write is lost
  assign hdr_we   = wr_en & ~soft_rst_i & (host_sel == SBCR_Q_HDR);
  assign opts_we  = wr_en & ~soft_rst_i & (host_sel == SBCR_Q_OPTS);

  // fixed bus name
  // a host write to this offset is acked and dropped
  assign busid_view = `SBCR_BUSID_VAL;

  // read-only nibbles forced
  // max request lives apart so the masked word never carries it
  assign opts_view = (opts_q & `SBCR_OPTS_WMASK) | `SBCR_OPTS_RO_VAL
                   | {16'h0000, maxrec_q, 12'h000};

  // wishbone handshake and read data
  always_comb begin
    ack_d  = take;
    rdat_d = rdat_q;
    // a write leaves the last read data standing
    if (take && !wb_we_i) begin
      unique case (host_sel)
        SBCR_Q_HDR:   rdat_d = hdr_q;
        SBCR_Q_BUSID: rdat_d = busid_view;
        SBCR_Q_OPTS:  rdat_d = opts_view;
        SBCR_Q_NONE:  rdat_d = `SBCR_RD_UNMAPPED;
      endcase
    end
  end

  // ack drops in the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // header register
  always_comb begin
    hdr_d = hdr_q;
    if (soft_rst_i) begin
      hdr_d = `SBCR_HDR_RST;
    end else if (hdr_we) begin
      hdr_d = sbcr_merge(hdr_q, wb_dat_i, wb_sel_i, `SBCR_HDR_WMASK);
    end
    // eeprom checksum load
    // eeprom wins over a coincident host write so the load is never lost
    if (eeprom_present_i && eeprom_crc_load_i) begin
      hdr_d[`SBCR_CRC_MSB:`SBCR_CRC_LSB] = eeprom_crc_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // reset upper zero
      // undefined checksum reset taken as zero
      hdr_q <= `SBCR_HDR_RST;
    end else begin
      hdr_q <= hdr_d;
    end
  end

  // bus options register, writable bits only
  always_comb begin
    opts_d = opts_q;
    if (soft_rst_i) begin
      opts_d = `SBCR_OPTS_RST;
    end else if (opts_we) begin
      opts_d = sbcr_merge(opts_q, wb_dat_i, wb_sel_i, `SBCR_OPTS_WMASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opts_q <= `SBCR_OPTS_RST;
    end else begin
      opts_q <= opts_d;
    end
  end

  // max request field kept apart: only a hard reset restores it
  always_comb begin
    maxrec_d = maxrec_q;
    if (opts_we && wb_sel_i[1]) begin
      maxrec_d = wb_dat_i[`SBCR_MAXREC_MSB:`SBCR_MAXREC_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      maxrec_q <= `SBCR_MAXREC_RST;
    end else begin
      maxrec_q <= maxrec_d;
    end
  end

  // the rom port answers from its own flops, so remote reads never stall the host
  // remote reads see live values
  sbcr_rom_port u_rom_port (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .req_i   (rom_rd_req_i),
    .addr_i  (rom_rd_addr_i),
    .hdr_i   (hdr_q),
    .busid_i (busid_view),
    .opts_i  (opts_view),
    .ack_o   (rom_rd_ack_o),
    .data_o  (rom_rd_data_o),
    .hit_o   (rom_rd_hit_o)
  );

  // outputs straight from their flip-flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule

`default_nettype wire

// ---- verification/sbcr_regs_properties.sv ----
/*
  port checker of the rom info register group, bound to sbcr_regs.
  assumes one clock and the synchronous hard reset of the design.
*/
`timescale 1ns/1ns
`include "sbcr_consts.svh"
`default_nettype none
module sbcr_regs_chk #(
  parameter int ADR_W = 8
)(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             rom_rd_req_i,
  input wire logic [47:0]      rom_rd_addr_i,
  input wire logic             rom_rd_ack_o,
  input wire logic [31:0]      rom_rd_data_o,
  input wire logic             rom_rd_hit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a taken read; ack low keeps it to the first cycle of the access
  wire logic rd_t = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_busid_read: assert property (rd_t && wb_adr_i[7:2] == 6'h07 |=> wb_dat_o == `SBCR_BUSID_VAL)
    else $error("bus id read wrong");
  a_opts_fixed: assert property (rd_t && wb_adr_i[7:2] == 6'h08 |=> (wb_dat_o & 32'h07000F0F) == 32'h00000002)
    else $error("options fixed bits wrong");
  a_rom_answer: assert property (rom_rd_req_i |=> rom_rd_ack_o) else $error("rom ack late");
  a_rom_hdr_hit: assert property (rom_rd_req_i && rom_rd_addr_i == `SBCR_ROM_HDR_ADDR |=> rom_rd_hit_o)
    else $error("rom header not mapped");
  a_rom_busid: assert property (rom_rd_req_i && rom_rd_addr_i == `SBCR_ROM_BUSID_ADDR
    |=> rom_rd_hit_o && rom_rd_data_o == `SBCR_BUSID_VAL) else $error("rom bus id wrong");
  a_rom_opts: assert property (rom_rd_req_i && rom_rd_addr_i == `SBCR_ROM_OPTS_ADDR
    |=> rom_rd_hit_o && (rom_rd_data_o & 32'h07000F0F) == 32'h00000002) else $error("rom options wrong");
  a_rom_miss: assert property (rom_rd_req_i && rom_rd_addr_i[47:12] != 36'hFFFFF0000 |=> !rom_rd_hit_o)
    else $error("rom hit on unmapped");
endmodule
bind sbcr_regs sbcr_regs_chk #(.ADR_W(ADR_W)) u_chk(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .rom_rd_req_i, .rom_rd_addr_i, .rom_rd_ack_o, .rom_rd_data_o, .rom_rd_hit_o);
`default_nettype wire

// ---- verification/sbcr_rom_node.sv ----
/*
  remote node reading configuration rom quadlets.
  assumes the rom port answers on clk_i one cycle after the request.
*/
`timescale 1ns/1ns
`default_nettype none
module sbcr_rom_node (
  input wire logic        clk_i,
  input wire logic        ack_i,
  input wire logic        hit_i,
  input wire logic [31:0] data_i,
  output logic            req_o = 1'h0,
  output logic [47:0]     addr_o = 48'h0
);
  task rq(input logic [47:0] a, output logic [31:0] d, output logic h);
    @(posedge clk_i);
    req_o <= 1'h1;
    addr_o <= a;
    @(posedge clk_i);
    req_o <= 1'h0;
    // released address shows no stale value
    addr_o <= ~a;
    @(posedge clk_i);
    d = data_i;
    h = hit_i & ack_i;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
/*
  testbench of sbcr_regs: wishbone host tasks and a remote rom reader.
  assumes the checker is bound by its own file.
*/
`timescale 1ns/1ns
`include "sbcr_consts.svh"
`default_nettype none
module tb;
  logic        clk_i = 1'h0, rst_i = 1'h1, soft_rst_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic        wb_we_i = 1'h0, eeprom_present_i = 1'h0, eeprom_crc_load_i = 1'h0, h;
  logic        rom_rd_req_i, rom_rd_ack_o, rom_rd_hit_o, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [3:0]  lanes = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rom_rd_data_o, q;
  logic [15:0] eeprom_crc_i = 16'h0;
  logic [47:0] rom_rd_addr_i;
  int          bad_count = 0, num_checks = 0;
  always #20 clk_i = ~clk_i;
  sbcr_regs u_dut(.clk_i, .rst_i, .soft_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .eeprom_present_i, .eeprom_crc_load_i, .eeprom_crc_i,
    .rom_rd_req_i, .rom_rd_addr_i, .rom_rd_ack_o, .rom_rd_data_o, .rom_rd_hit_o);
  sbcr_rom_node u_node(.clk_i, .ack_i(rom_rd_ack_o), .hit_i(rom_rd_hit_o), .data_i(rom_rd_data_o),
    .req_o(rom_rd_req_i), .addr_o(rom_rd_addr_i));
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= lanes;
    wb_dat_i <= d;
    // only the watchdog ends a hung access
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_dat_i <= ~d;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  task rr(input logic [47:0] a, input logic [31:0] e, input logic eh);
    u_node.rq(a, q, h);
    chk(q, e);
    chk({31'h0, h}, {31'h0, eh});
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(8'h18, 32'h0);
    rd(8'h20, 32'h0000A002);
    rd(8'h1C, `SBCR_BUSID_VAL);
    rd(8'h00, 32'h0);
    rr(`SBCR_ROM_HDR_ADDR, 32'h0, 1'h1);
    rr(48'h000000000400, 32'h0, 1'h0);
    $display("test reset done");
    wb(1'h1, 8'h18, 32'h12345678);
    rr(`SBCR_ROM_HDR_ADDR, 32'h12345678, 1'h1);
    wb(1'h1, 8'h1C, 32'h0);
    rd(8'h1C, `SBCR_BUSID_VAL);
    rr(`SBCR_ROM_BUSID_ADDR, `SBCR_BUSID_VAL, 1'h1);
    wb(1'h1, 8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'hF8FFF0F2);
    rr(`SBCR_ROM_OPTS_ADDR, 32'hF8FFF0F2, 1'h1);
    lanes = 4'h2;
    wb(1'h1, 8'h20, 32'h00003000);
    lanes = 4'hF;
    rd(8'h20, 32'hF8FF30F2);
    $display("test writes done");
    @(posedge clk_i);
    eeprom_crc_i <= 16'hBEEF;
    eeprom_crc_load_i <= 1'h1;
    @(posedge clk_i);
    eeprom_crc_load_i <= 1'h0;
    rd(8'h18, 32'h12345678);
    @(posedge clk_i);
    eeprom_present_i <= 1'h1;
    eeprom_crc_load_i <= 1'h1;
    @(posedge clk_i);
    eeprom_crc_load_i <= 1'h0;
    rd(8'h18, 32'h1234BEEF);
    fork
      wb(1'h1, 8'h18, 32'hAAAA5555);
      begin
        repeat (2) @(posedge clk_i);
        eeprom_crc_i <= 16'hC0DE;
        eeprom_crc_load_i <= 1'h1;
        @(posedge clk_i);
        eeprom_crc_load_i <= 1'h0;
      end
    join
    rd(8'h18, 32'hAAAAC0DE);
    rr(`SBCR_ROM_HDR_ADDR, 32'hAAAAC0DE, 1'h1);
    @(posedge clk_i);
    soft_rst_i <= 1'h1;
    @(posedge clk_i);
    soft_rst_i <= 1'h0;
    rd(8'h20, 32'h00003002);
    rd(8'h18, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(8'h20, 32'h0000A002);
    rd(8'h18, 32'h0);
    $display("test resets done");
    test_done();
  end
endmodule
`default_nettype wire
